// ==== core/rar_pkg.sv ====
package rar_pkg;
    // Word offsets of the two routing registers.
    localparam logic [7:0] LINE_ONE_ROUTING_OFFSET = 8'h16;
    localparam logic [7:0] LINE_TWO_ROUTING_OFFSET = 8'h17;
    // Printed offsets are not multiples of four, so they are word indices.
    localparam int unsigned REG_BYTE_SHIFT = 2;
    localparam logic [11:0] LINE_ONE_ADDR = 12'h058;
    localparam logic [11:0] LINE_TWO_ADDR = 12'h05c;

    // Field positions shared by both registers.
    localparam int unsigned DIFF_BIT   = 7;
    localparam int unsigned LEVEL_LSB  = 3;
    localparam int unsigned AUX_BIT    = 2;
    localparam int unsigned LEVEL_W    = 4;

    // Values after reset.
    localparam logic [7:0] LINE_ONE_RESET = 8'h78;
    localparam logic [7:0] LINE_TWO_RESET = 8'h78;

    // Level codes.
    localparam logic [3:0] LEVEL_OFF     = 4'hf;
    localparam logic [3:0] LEVEL_MAX_ATT = 4'h8;
    localparam logic [3:0] LEVEL_TWO_MID = 4'h4;

    // Soft-step rate codes.
    localparam logic [1:0] STEP_EVERY_FS = 2'h0;
    localparam logic [1:0] STEP_TWO_FS   = 2'h1;

    // Sample rate for step pacing; 48 kHz at 100 MHz.
    localparam int unsigned CLK_HZ        = 100000000;
    localparam int unsigned FS_HZ         = 48000;
    localparam int unsigned FS_CYCLES     = CLK_HZ / FS_HZ;
    localparam logic [11:0] FS_CYCLES_M1  = 12'(FS_CYCLES - 1);

    // Bus responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        RAR_ST_IDLE = 2'b00,
        RAR_ST_HOLD = 2'b01
    } rar_step_e;
endpackage : rar_pkg

// ==== core/rar_gain_stepper.sv ====
// Moves an applied level code toward its target, step_size codes per pacing tick.
module rar_gain_stepper
    import rar_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [3:0] target,
    input  wire logic       tick,
    input  wire logic       bypass,
    input  wire logic [3:0] step_size,
    output logic      [3:0] applied
);
    logic [3:0] applied_ff;
    logic [3:0] nxt_applied;

    // A disconnect or reconnect is a switch, not a gain move, so it applies at once.
    always_comb begin
        nxt_applied = applied_ff;
        if (bypass || target == LEVEL_OFF || applied_ff == LEVEL_OFF) begin
            nxt_applied = target;
        end else if (tick && applied_ff < target) begin
            nxt_applied = ((target - applied_ff) < step_size) ? target : 4'(applied_ff + step_size);
        end else if (tick && applied_ff > target) begin
            nxt_applied = ((applied_ff - target) < step_size) ? target : 4'(applied_ff - step_size);
        end
    end

    // Registered so the analog control changes on clean clock edges.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            applied_ff <= LEVEL_OFF;
        end else begin
            applied_ff <= nxt_applied;
        end
    end

    assign applied = applied_ff;
endmodule : rar_gain_stepper

// ==== core/rar_routing_regs.sv ====
module rar_routing_regs
    import rar_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             right_line_input_one_diff,
    output logic             right_line_input_one_connect,
    output logic [3:0]       right_line_input_one_level,
    output logic             right_line_input_two_diff,
    output logic             right_line_input_two_connect,
    output logic [3:0]       right_line_input_two_level,
    output logic             right_adc_power_up,
    output logic             right_weak_cm_bias
);
    // Register storage and bus handshake state.
    logic [7:0]  line_one_ff, nxt_line_one;
    logic [7:0]  line_two_ff, nxt_line_two;
    logic        aw_held_ff, nxt_aw_held;
    logic [11:0] aw_addr_ff, nxt_aw_addr;
    logic        w_held_ff, nxt_w_held;
    logic [7:0]  w_data_ff, nxt_w_data;
    logic        w_strb_ff, nxt_w_strb;
    logic        bvalid_ff, nxt_bvalid;
    logic [1:0]  bresp_ff, nxt_bresp;
    logic        rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0]  rresp_ff, nxt_rresp;

    // Pacing of gain steps and registered analog controls.
    rar_step_e   pace_ff, nxt_pace;
    logic [11:0] fs_cnt_ff, nxt_fs_cnt;
    logic        tick_ff, nxt_tick;
    logic        one_diff_ff, one_conn_ff, two_diff_ff, two_conn_ff, pwr_ff, bias_ff;
    logic        nxt_one_conn, nxt_two_conn;
    logic        nxt_one_diff, nxt_two_diff, nxt_pwr, nxt_bias;
    logic [3:0]  one_level, two_level;
    logic        step_bypass;
    logic        do_write;

    // A write goes ahead once both address and data are held and no response is pending.
    // A second address may be held meanwhile; it waits here until the response is taken,
    // so a slow master can never have two writes land against one response.
    assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;

    // Write channel: address and data are accepted in either order.
    // Each half is held in its own flop, so the master may offer them in any cycle.
    always_comb begin
        nxt_aw_held  = aw_held_ff;
        nxt_aw_addr  = aw_addr_ff;
        nxt_w_held   = w_held_ff;
        nxt_w_data   = w_data_ff;
        nxt_w_strb   = w_strb_ff;
        nxt_bvalid   = bvalid_ff;
        nxt_bresp    = bresp_ff;
        nxt_line_one = line_one_ff;
        nxt_line_two = line_two_ff;
        if (s_axi_awvalid && !aw_held_ff) begin
            nxt_aw_held = 1'b1;
            nxt_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held_ff) begin
            nxt_w_held = 1'b1;
            nxt_w_data = s_axi_wdata[7:0];
            nxt_w_strb = s_axi_wstrb[0];
        end
        if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (do_write) begin
            nxt_aw_held = 1'b0;
            nxt_w_held  = 1'b0;
            nxt_bvalid  = 1'b1;
            nxt_bresp   = RESP_OKAY;
            // Only byte lane 0 holds storage; a write without it changes nothing.
            // Low address bits are ignored, so any byte address inside a word selects it.
            if (aw_addr_ff[11:2] == LINE_ONE_ADDR[11:2]) begin
                if (w_strb_ff) begin
                    nxt_line_one = w_data_ff;
                end
            end else if (aw_addr_ff[11:2] == LINE_TWO_ADDR[11:2]) begin
                if (w_strb_ff) begin
                    nxt_line_two = {w_data_ff[7:2], 2'h0};
                end
            end else begin
                nxt_bresp = RESP_SLVERR;
            end
        end
    end

    // Write channel flops; reset leaves every ready high and no response pending.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line_one_ff <= LINE_ONE_RESET;
            line_two_ff <= LINE_TWO_RESET;
            aw_held_ff  <= 1'b0;
            aw_addr_ff  <= 12'h000;
            w_held_ff   <= 1'b0;
            w_data_ff   <= 8'h00;
            w_strb_ff   <= 1'b0;
            bvalid_ff   <= 1'b0;
            bresp_ff    <= RESP_OKAY;
        end else begin
            line_one_ff <= nxt_line_one;
            line_two_ff <= nxt_line_two;
            aw_held_ff  <= nxt_aw_held;
            aw_addr_ff  <= nxt_aw_addr;
            w_held_ff   <= nxt_w_held;
            w_data_ff   <= nxt_w_data;
            w_strb_ff   <= nxt_w_strb;
            bvalid_ff   <= nxt_bvalid;
            bresp_ff    <= nxt_bresp;
        end
    end

    // Read channel: one read at a time, answered the cycle after acceptance.
    // Data is captured at acceptance, so a write landing next cycle cannot tear the answer.
    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata  = rdata_ff;
        nxt_rresp  = rresp_ff;
        if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_ff) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = RESP_OKAY;
            nxt_rdata  = 32'h0000_0000;
            // Unmapped reads answer zero with an error, so software can tell a miss from a value.
            if (s_axi_araddr[11:2] == LINE_ONE_ADDR[11:2]) begin
                nxt_rdata = {24'h00_0000, line_one_ff};
            end else if (s_axi_araddr[11:2] == LINE_TWO_ADDR[11:2]) begin
                nxt_rdata = {24'h00_0000, line_two_ff};
            end else begin
                nxt_rresp = RESP_SLVERR;
            end
        end
    end

    // Read channel flops.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= RESP_OKAY;
        end else begin
            rvalid_ff <= nxt_rvalid;
            rdata_ff  <= nxt_rdata;
            rresp_ff  <= nxt_rresp;
        end
    end

    // Sample-rate pacing: a tick every sample period, or every second one.
    // The counter runs free, so the first step after a write comes up to one period late, or two when stepping every second period.
    always_comb begin
        nxt_fs_cnt = fs_cnt_ff;
        nxt_pace   = pace_ff;
        nxt_tick   = 1'b0;
        if (fs_cnt_ff == FS_CYCLES_M1) begin
            nxt_fs_cnt = 12'h000;
            case (pace_ff)
                RAR_ST_IDLE: begin
                    nxt_tick = 1'b1;
                    if (line_one_ff[1:0] == STEP_TWO_FS) begin
                        nxt_pace = RAR_ST_HOLD;
                    end
                end
                RAR_ST_HOLD: begin
                    nxt_pace = RAR_ST_IDLE;
                end
                default: begin
                    nxt_pace = RAR_ST_IDLE;
                end
            endcase
        end else begin
            nxt_fs_cnt = 12'(fs_cnt_ff + 12'h001);
        end
    end

    // Pacing flops; the tick is registered so both steppers see it on the same edge.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fs_cnt_ff <= 12'h000;
            pace_ff   <= RAR_ST_IDLE;
            tick_ff   <= 1'b0;
        end else begin
            fs_cnt_ff <= nxt_fs_cnt;
            pace_ff   <= nxt_pace;
            tick_ff   <= nxt_tick;
        end
    end

    // Codes 10 and 11 turn stepping off, so new levels apply at once.
    // Both steppers share this bypass, as the stepping control lives in the first register.
    assign step_bypass = line_one_ff[1];

    // Input one walks one 1.5 dB code per tick.
    // A level change and a tick in one cycle move the level at once toward the new target.
    rar_gain_stepper u_step_one (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .target    (line_one_ff[LEVEL_LSB +: LEVEL_W]),
        .tick      (tick_ff),
        .bypass    (step_bypass),
        .step_size (4'h1),
        .applied   (one_level)
    );

    // Input two has only 6 dB steps, so it walks four codes per tick.
    // Reserved targets are walked to like any other; keeping them out is left to software.
    rar_gain_stepper u_step_two (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .target    (line_two_ff[LEVEL_LSB +: LEVEL_W]),
        .tick      (tick_ff),
        .bypass    (step_bypass),
        .step_size (LEVEL_TWO_MID),
        .applied   (two_level)
    );

    // Connection follows the stored code rather than the applied level, so a disconnect
    // takes effect at once even while a gain step is under way; reserved codes are stored as written.
    always_comb begin
        nxt_one_diff = line_one_ff[DIFF_BIT];
        nxt_one_conn = (line_one_ff[LEVEL_LSB +: LEVEL_W] <= LEVEL_MAX_ATT);
        nxt_two_diff = line_two_ff[DIFF_BIT];
        nxt_two_conn = (line_two_ff[LEVEL_LSB +: LEVEL_W] != LEVEL_OFF);
        nxt_pwr      = line_one_ff[AUX_BIT];
        nxt_bias     = line_two_ff[AUX_BIT];
    end

    // Analog controls are registered so every output leaves a flip-flop.
    // One cycle of lag behind the register is negligible against analog settling.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            one_diff_ff <= 1'b0;
            one_conn_ff <= 1'b0;
            two_diff_ff <= 1'b0;
            two_conn_ff <= 1'b0;
            pwr_ff      <= 1'b0;
            bias_ff     <= 1'b0;
        end else begin
            one_diff_ff <= nxt_one_diff;
            one_conn_ff <= nxt_one_conn;
            two_diff_ff <= nxt_two_diff;
            two_conn_ff <= nxt_two_conn;
            pwr_ff      <= nxt_pwr;
            bias_ff     <= nxt_bias;
        end
    end

    // Bus handshake outputs come straight from the held and valid flops.
    assign s_axi_awready                = !aw_held_ff;
    assign s_axi_wready                 = !w_held_ff;
    assign s_axi_bvalid                 = bvalid_ff;
    assign s_axi_bresp                  = bresp_ff;
    assign s_axi_arready                = !rvalid_ff;
    assign s_axi_rvalid                 = rvalid_ff;
    assign s_axi_rdata                  = rdata_ff;
    assign s_axi_rresp                  = rresp_ff;

    // Analog controls and applied levels leave their flip-flops directly.
    assign right_line_input_one_diff    = one_diff_ff;
    assign right_line_input_one_connect = one_conn_ff;
    assign right_line_input_one_level   = one_level;
    assign right_line_input_two_diff    = two_diff_ff;
    assign right_line_input_two_connect = two_conn_ff;
    assign right_line_input_two_level   = two_level;
    assign right_adc_power_up           = pwr_ff;
    assign right_weak_cm_bias           = bias_ff;
endmodule : rar_routing_regs

// ==== testbench/rar_routing_regs_monitor.sv ====
module rar_routing_regs_monitor
    import rar_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        right_line_input_one_connect,
    input wire logic [3:0]  right_line_input_one_level,
    input wire logic        right_line_input_two_connect,
    input wire logic [3:0]  right_line_input_two_level
);
    // Everything here lives in the bus clock domain and is muted in reset.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Both halves of a write are taken at one edge by this bench.
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_WR_ANSWER: assert property (s_wr_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    AST_WR_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_RD_ANSWER: assert property (s_rd_taken |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    AST_RD_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read upper bits set");
    // Connect follows the stored code while the level may still be moving.
    AST_ONE_LEVEL: assert property (right_line_input_one_connect [*3] |-> right_line_input_one_level <= 4'h8)
        else $error("input one level off while connected");
    AST_TWO_LEVEL: assert property (right_line_input_two_connect [*3] |-> right_line_input_two_level != LEVEL_OFF)
        else $error("input two level off while connected");
    AST_TWO_OFF: assert property (!right_line_input_two_connect [*3] |-> right_line_input_two_level == LEVEL_OFF)
        else $error("input two level on while disconnected");
    AST_TWO_CODES: assert property (right_line_input_two_level inside {4'h0, 4'h4, 4'h8, 4'hf})
        else $error("input two level not a supported code");
endmodule : rar_routing_regs_monitor

bind rar_routing_regs rar_routing_regs_monitor rar_routing_regs_monitor_i (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .right_line_input_one_connect,
    .right_line_input_one_level, .right_line_input_two_connect, .right_line_input_two_level);

// ==== testbench/tb.sv ====
module tb
    import rar_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h0, right_line_input_one_level, right_line_input_two_level;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        right_line_input_one_diff, right_line_input_one_connect, right_adc_power_up;
    logic        right_line_input_two_diff, right_line_input_two_connect, right_weak_cm_bias;
    logic [7:0]  mdl1 = 8'h78, mdl2 = 8'h78;
    int          failures = 0, n_tests = 0;
    wire  [13:0] pins = {right_line_input_one_diff, right_line_input_one_connect, right_line_input_one_level,
        right_line_input_two_diff, right_line_input_two_connect, right_line_input_two_level,
        right_adc_power_up, right_weak_cm_bias};

    rar_routing_regs rar_routing_regs_i (.*);

    // Free-running 100 MHz bus clock.
    initial forever #5 aclk = ~aclk;

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    // A wait that ran out means the design hung, so there is no point going on.
    task automatic guard(input bit ok);
        if (!ok) begin
            failures++;
            $display("ERROR %0t: wait ran out", $time);
            end_sim();
        end
    endtask : guard

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: word %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: response %h expected %h", $time, got, exp);
        end
    endtask : chk_resp

    task automatic chk_pins(input logic [13:0] got, input logic [13:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: outputs %h expected %h", $time, got, exp);
        end
    endtask : chk_pins

    function automatic bit hit(input logic [11:0] a);
        return a == LINE_ONE_ADDR || a == LINE_TWO_ADDR;
    endfunction : hit

    // Expected pins once a level has fully settled at its target.
    function automatic logic [13:0] exp_pins();
        return {mdl1[7], mdl1[6:3] <= 4'h8, mdl1[6:3], mdl2[7], mdl2[6:3] != LEVEL_OFF, mdl2[6:3], mdl1[2], mdl2[2]};
    endfunction : exp_pins

    task automatic settle_chk();
        repeat (4) @(posedge aclk);
        chk_pins(pins, exp_pins());
    endtask : settle_chk

    // Upper data bits carry noise; only lane 0 may matter.
    task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
        logic [1:0] r;
        bit         done;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= {24'($urandom), d};
        s_axi_wstrb   <= s;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        done = 1'b0;
        for (int i = 0; i < 20 && !done; i++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1'b1;
            end
        end
        guard(done);
        if (s[0] && a == LINE_ONE_ADDR) mdl1 = d;
        if (s[0] && a == LINE_TWO_ADDR) mdl2 = d & 8'hfc;
        chk_resp(r, hit(a) ? RESP_OKAY : RESP_SLVERR);
    endtask : axi_wr

    task automatic axi_rd(input logic [11:0] a);
        logic [31:0] q;
        logic [1:0]  r;
        bit          done;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        done = 1'b0;
        for (int i = 0; i < 20 && !done; i++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                q = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1'b1;
            end
        end
        guard(done);
        chk_word(q, a == LINE_ONE_ADDR ? {24'h0, mdl1} : a == LINE_TWO_ADDR ? {24'h0, mdl2} : 32'h0);
        chk_resp(r, hit(a) ? RESP_OKAY : RESP_SLVERR);
    endtask : axi_rd

    // The tick phase is free-running, so only a window of cycles can be required.
    task automatic step_wait(input logic [3:0] t1, input logic [3:0] t2, input int lo, input int hi);
        int cnt;
        cnt = 0;
        while (cnt <= hi && !(right_line_input_one_level === t1 && right_line_input_two_level === t2)) begin
            @(posedge aclk);
            cnt++;
        end
        guard(cnt <= hi);
        chk_word(32'(cnt >= lo), 32'h1);
        settle_chk();
    endtask : step_wait

    // Main sequence: reset, odd accesses, levels 0 to 8 and off on input one and codes 0, 4, 8 and off on input two, then paced stepping.
    initial begin
        logic [3:0] lv;
        logic [3:0] two_codes [4];
        two_codes = '{4'h0, LEVEL_TWO_MID, LEVEL_MAX_ATT, LEVEL_OFF};
        void'($urandom(32'hb250));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        settle_chk();
        axi_rd(LINE_ONE_ADDR);
        axi_rd(LINE_TWO_ADDR);
        axi_wr(12'h060, 8'hff, 4'hf);
        axi_rd(12'h060);
        axi_wr(LINE_ONE_ADDR, 8'hff, 4'he);
        axi_rd(LINE_ONE_ADDR);
        axi_wr(LINE_TWO_ADDR, 8'h83, 4'hf);
        axi_rd(LINE_TWO_ADDR);
        for (int i = 0; i < 20; i++) begin
            lv = (i % 10 == 9) ? LEVEL_OFF : 4'(i % 10);
            axi_wr(LINE_ONE_ADDR, {1'($urandom), lv, 1'($urandom), 1'b1, 1'($urandom)}, 4'hf);
            axi_wr(LINE_TWO_ADDR, {1'($urandom), two_codes[i % 4], 1'($urandom), 2'b00}, 4'hf);
            settle_chk();
            axi_rd(LINE_ONE_ADDR);
            axi_rd(LINE_TWO_ADDR);
        end
        axi_wr(LINE_ONE_ADDR, 8'h07, 4'hf);
        axi_wr(LINE_TWO_ADDR, 8'h40, 4'hf);
        settle_chk();
        axi_wr(LINE_ONE_ADDR, 8'h44, 4'hf);
        axi_wr(LINE_TWO_ADDR, 8'h00, 4'hf);
        step_wait(4'h8, 4'h0, 7 * FS_CYCLES - 20, 8 * FS_CYCLES + 20);
        axi_wr(LINE_ONE_ADDR, 8'h25, 4'hf);
        step_wait(4'h4, 4'h0, 6 * FS_CYCLES - 20, 8 * FS_CYCLES + 20);
        end_sim();
    end
endmodule : tb
